/* logic/lvdc_pkg.sv */
// constants and carrier types of the low-voltage detector control
`default_nettype none
package lvdc_pkg;
  // width of the stored detection level (upper nibble must stay zero)
  localparam int LEVEL_W = 4;
  // full width of the level select write port
  localparam int LEVEL_REG_W = 8;
  // value of the level select register after reset
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
  // clock period and detector settling time
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAB_TIME_US = 200;
  // settling time as cycles, a longest time so it rounds down
  localparam int STAB_CYC = (STAB_TIME_US * 1000) / CLK_PERIOD_NS;
  // width of the settling counter
  localparam int STAB_CNT_W = 16;

  // action on a detected low voltage
  typedef enum logic
  {
    LVDC_ACT_IRQ = 1'b0,
    LVDC_ACT_RESET = 1'b1
  } lvdc_action_e;

  // what the comparator watches
  typedef enum logic
  {
    LVDC_SRC_SUPPLY = 1'b0,
    LVDC_SRC_PIN = 1'b1
  } lvdc_source_e;

  // control register contents
  typedef struct packed
  {
    logic detector_enable;
    lvdc_action_e detect_action_mode;
    lvdc_source_e detect_source_select;
  } lvdc_ctrl_s;

  // control register value after reset
  localparam lvdc_ctrl_s CTRL_RST = '{1'b0, LVDC_ACT_IRQ, LVDC_SRC_SUPPLY};
endpackage
`default_nettype wire

/* logic/lvdc_core.sv */
// low-voltage detector control: enable, source, level, flag and reset
`default_nettype none
// Summary of operation
// - disabling while supply low may still interrupt
// - source one compares the external pin
// - enabling the detector may set the flag
// - level write while running may set flag
// - pin source ignores the level setting
// - reset mode when voltage fine: no reset
// - enable zero means no detection at all
// - default start re-enables after reset release
// - warm reset with default start skips settling, detection unreliable
module lvdc_core #(
  parameter int STAB_CYCLES = lvdc_pkg::STAB_CYC,
  parameter int CNT_W = lvdc_pkg::STAB_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire lvdc_pkg::lvdc_ctrl_s ctrl_wdata,
  input wire logic level_wr,
  input wire logic [lvdc_pkg::LEVEL_REG_W-1:0] level_wdata,
  input wire logic detector_irq_mask,
  input wire logic irq_flag_clr,
  input wire logic default_start_disable,
  input wire logic warm_reset_cause,
  input wire logic supply_below,
  input wire logic pin_below,
  output logic detector_enable,
  output lvdc_pkg::lvdc_action_e detect_action_mode,
  output lvdc_pkg::lvdc_source_e detect_source_select,
  output logic [lvdc_pkg::LEVEL_W-1:0] supply_detect_level,
  output logic detect_valid,
  output logic detector_irq_flag,
  output logic detector_irq_request,
  output logic irq_pending,
  output logic internal_reset_req
);
  // stored control settings
  lvdc_pkg::lvdc_ctrl_s ctrl_r;
  // stored detection level for the supply comparator
  logic [lvdc_pkg::LEVEL_W-1:0] level_r;
  // low for the first cycle after reset release
  logic boot_done_r;
  // settling counter, saturates at its target
  logic [CNT_W-1:0] stab_cnt_r;
  // qualified detection and its previous value
  logic low_det;
  logic low_det_prev_r;
  // flag, request pulse and reset request
  logic irq_flag_r;
  logic irq_req_r;
  logic rst_req_r;
  // settling target at counter width
  logic [CNT_W-1:0] stab_target;
  // individual flag set causes
  logic set_on_enable;
  logic set_on_level_wr;
  logic set_on_disable;
  logic set_on_detect;
  logic irq_set;
  logic stable;
  logic sel_below;

  assign stab_target = CNT_W'(STAB_CYCLES);
  assign stable = (stab_cnt_r == stab_target);

  // first clock after release marks the start of the processor
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      boot_done_r <= 1'b0;
    else
      boot_done_r <= 1'b1;
  end

  // control register; the enable strap is caught after release
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl_r <= lvdc_pkg::CTRL_RST;
    else if (!boot_done_r)
      // default start turns the detector on whatever it was
      ctrl_r.detector_enable <= !default_start_disable;
    else if (ctrl_wr)
      ctrl_r <= ctrl_wdata;
  end

  // level register; only the low nibble is kept
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      level_r <= lvdc_pkg::LEVEL_RST;
    else if (level_wr)
      level_r <= level_wdata[lvdc_pkg::LEVEL_W-1:0];
  end

  // settling counter: a warm restart with default start skips it,
  // so early detections may be wrong until the analog part settles
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      stab_cnt_r <= '0;
    else if (!boot_done_r && !default_start_disable && warm_reset_cause)
      stab_cnt_r <= stab_target;
    else if (!ctrl_r.detector_enable)
      stab_cnt_r <= '0;
    else if (!stable)
      stab_cnt_r <= stab_cnt_r + CNT_W'(1);
  end

  // pick the comparator; the pin has a fixed level so level_r is unused
  always_comb
  begin
    case (ctrl_r.detect_source_select)
      lvdc_pkg::LVDC_SRC_PIN: sel_below = pin_below;
      lvdc_pkg::LVDC_SRC_SUPPLY: sel_below = supply_below;
      default: sel_below = 1'b0;
    endcase
  end

  // no detection while disabled or still settling
  assign low_det = ctrl_r.detector_enable && stable && sel_below;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      low_det_prev_r <= 1'b0;
    else
      low_det_prev_r <= low_det;
  end

  // spurious set causes of the analog front end
  assign set_on_enable = boot_done_r && ctrl_wr &&
    ctrl_wdata.detector_enable && !ctrl_r.detector_enable;
  assign set_on_level_wr = level_wr && ctrl_r.detector_enable;
  assign set_on_disable = boot_done_r && ctrl_wr &&
    !ctrl_wdata.detector_enable && ctrl_r.detector_enable &&
    ctrl_r.detect_action_mode == lvdc_pkg::LVDC_ACT_IRQ &&
    ctrl_r.detect_source_select == lvdc_pkg::LVDC_SRC_SUPPLY &&
    supply_below;
  // a genuine falling voltage in interrupt mode
  assign set_on_detect = low_det && !low_det_prev_r &&
    ctrl_r.detect_action_mode == lvdc_pkg::LVDC_ACT_IRQ;
  assign irq_set = set_on_enable || set_on_level_wr ||
    set_on_disable || set_on_detect;

  // sticky flag: a set in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_flag_r <= 1'b0;
    else if (irq_set)
      irq_flag_r <= 1'b1;
    else if (irq_flag_clr)
      irq_flag_r <= 1'b0;
  end

  // one-cycle request toward the interrupt controller
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_req_r <= 1'b0;
    else
      irq_req_r <= irq_set;
  end

  // reset request follows the level, so selecting reset mode while
  // the voltage is fine gives nothing
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rst_req_r <= 1'b0;
    else
      rst_req_r <= low_det &&
        ctrl_r.detect_action_mode == lvdc_pkg::LVDC_ACT_RESET;
  end

  assign detector_enable = ctrl_r.detector_enable;
  assign detect_action_mode = ctrl_r.detect_action_mode;
  assign detect_source_select = ctrl_r.detect_source_select;
  assign supply_detect_level = level_r;
  assign detect_valid = stable;
  assign detector_irq_flag = irq_flag_r;
  assign detector_irq_request = irq_req_r;
  // mask only gates the pending line, the flag still records
  assign irq_pending = irq_flag_r && !detector_irq_mask;
  assign internal_reset_req = rst_req_r;

  // checks next to the logic
  disable_low_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    set_on_disable |=> detector_irq_request && detector_irq_flag)
    else $error("disable while supply low gave no request");
  pin_source_a: assert property (@(posedge core_clk) disable iff (rst)
    (detector_enable && stable &&
     detect_source_select == lvdc_pkg::LVDC_SRC_PIN && !pin_below)
    |-> !low_det)
    else $error("pin source detected without pin low");
  enable_set_a: assert property (@(posedge core_clk) disable iff (rst)
    (boot_done_r && ctrl_wr && ctrl_wdata.detector_enable &&
     !detector_enable) |=> detector_irq_flag)
    else $error("enabling did not set the flag");
  level_wr_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    (level_wr && detector_enable) |=> detector_irq_flag)
    else $error("level write while running left flag clear");
  level_ignored_a: assert property (@(posedge core_clk) disable iff (rst)
    (detect_source_select == lvdc_pkg::LVDC_SRC_PIN && !pin_below)
    |=> !internal_reset_req)
    else $error("reset without pin low on pin source");
  no_reset_high_a: assert property (@(posedge core_clk) disable iff (rst)
    !sel_below |=> !internal_reset_req)
    else $error("reset while voltage above level");
  disabled_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    !detector_enable |=> !internal_reset_req && !low_det_prev_r)
    else $error("detection while disabled");
  default_start_a: assert property (@(posedge core_clk) disable iff (rst)
    (!boot_done_r && !default_start_disable) |=> detector_enable)
    else $error("default start did not enable");
  warm_skip_a: assert property (@(posedge core_clk) disable iff (rst)
    (!boot_done_r && !default_start_disable && warm_reset_cause)
    |=> detect_valid)
    else $error("warm restart still waiting to settle");
  mode_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    (low_det && detect_action_mode == lvdc_pkg::LVDC_ACT_RESET)
    |=> internal_reset_req ##1 ($stable(detector_irq_flag) ||
    $past(irq_set) || $past(irq_flag_clr)))
    else $error("reset mode did not request reset");
endmodule
`default_nettype wire

/* tb/low_voltage_detect_control_tb.sv */
// self-checking bench for the low-voltage detector control core
`default_nettype none
module low_voltage_detect_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short settling count keeps the run brief
  localparam int STAB = 8;
  logic core_clk = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, level_wr = 1'b0;
  lvdc_pkg::lvdc_ctrl_s ctrl_wdata = lvdc_pkg::CTRL_RST;
  logic [7:0] level_wdata = 8'h00;
  logic detector_irq_mask = 1'b0, irq_flag_clr = 1'b0;
  logic default_start_disable = 1'b1, warm_reset_cause = 1'b0;
  logic supply_below = 1'b0, pin_below = 1'b0;
  logic detector_enable, detect_valid, detector_irq_flag;
  logic detector_irq_request, irq_pending, internal_reset_req, req_seen;
  lvdc_pkg::lvdc_action_e detect_action_mode;
  lvdc_pkg::lvdc_source_e detect_source_select;
  logic [3:0] supply_detect_level;
  int failures = 0, checked = 0, cycles = 0;
  lvdc_core #(.STAB_CYCLES(STAB), .CNT_W(16)) u_lvdc_core (.core_clk(core_clk),
    .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .level_wr(level_wr), .level_wdata(level_wdata),
    .detector_irq_mask(detector_irq_mask), .irq_flag_clr(irq_flag_clr),
    .default_start_disable(default_start_disable),
    .warm_reset_cause(warm_reset_cause), .supply_below(supply_below),
    .pin_below(pin_below), .detector_enable(detector_enable),
    .detect_action_mode(detect_action_mode),
    .detect_source_select(detect_source_select),
    .supply_detect_level(supply_detect_level), .detect_valid(detect_valid),
    .detector_irq_flag(detector_irq_flag),
    .detector_irq_request(detector_irq_request), .irq_pending(irq_pending),
    .internal_reset_req(internal_reset_req));
  // 8 ns clock
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  // hang guard: the tests need well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // single-bit result
  task automatic chk_bit(logic got, logic exp, string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask
  // stored level result
  task automatic chk_lvl(logic [3:0] got, logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t level got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // control write; the request pulse rises on the same edge as the flag and is sampled over two edges
  task automatic wctrl(logic en, lvdc_pkg::lvdc_action_e act,
                       lvdc_pkg::lvdc_source_e src);
    ctrl_wdata = '{en, act, src};
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    req_seen = detector_irq_request;
    cyc(1);
    req_seen = req_seen | detector_irq_request;
  endtask
  task automatic wlvl(logic [7:0] v);
    level_wdata = v;
    level_wr = 1'b1;
    cyc(1);
    level_wr = 1'b0;
  endtask
  task automatic clr();
    irq_flag_clr = 1'b1;
    cyc(1);
    irq_flag_clr = 1'b0;
    cyc(1);
  endtask
  // reset with given straps, returns one edge after release
  task automatic do_rst(logic dsd, logic warm, int n);
    rst = 1'b1;
    default_start_disable = dsd;
    warm_reset_cause = warm;
    cyc(n);
    rst = 1'b0;
    cyc(1);
  endtask
  initial
  begin
    @(negedge core_clk);
    do_rst(1'b1, 1'b0, 20);
    chk_bit(detector_enable, 1'b0, "enable off");
    // low supply while disabled must go unnoticed
    supply_below = 1'b1;
    cyc(12);
    chk_bit(detector_irq_flag, 1'b0, "flag idle");
    chk_bit(detect_valid, 1'b0, "valid idle");
    supply_below = 1'b0;
    wctrl(1'b1, lvdc_pkg::LVDC_ACT_IRQ, lvdc_pkg::LVDC_SRC_SUPPLY);
    chk_bit(detector_enable, 1'b1, "enable on");
    chk_bit(detector_irq_flag, 1'b1, "flag on enable");
    chk_bit(req_seen, 1'b1, "request on enable");
    clr();
    cyc(STAB + 2);
    chk_bit(detect_valid, 1'b1, "settled");
    // level change while running, masked first
    detector_irq_mask = 1'b1;
    wlvl(8'h05);
    cyc(1);
    chk_lvl(supply_detect_level, 4'h5);
    chk_bit(detector_irq_flag, 1'b1, "flag on level");
    chk_bit(irq_pending, 1'b0, "masked");
    clr();
    detector_irq_mask = 1'b0;
    cyc(1);
    chk_bit(irq_pending, 1'b0, "unmasked clean");
    supply_below = 1'b1;
    cyc(3);
    chk_bit(irq_pending, 1'b1, "low supply irq");
    clr();
    // disabling while the supply is still low
    wctrl(1'b0, lvdc_pkg::LVDC_ACT_IRQ, lvdc_pkg::LVDC_SRC_SUPPLY);
    chk_bit(detector_irq_flag, 1'b1, "flag on disable");
    chk_bit(req_seen, 1'b1, "request on disable");
    supply_below = 1'b0;
    clr();
    wctrl(1'b1, lvdc_pkg::LVDC_ACT_IRQ, lvdc_pkg::LVDC_SRC_PIN);
    chk_bit(detect_source_select, 1'b1, "pin source");
    clr();
    cyc(STAB + 2);
    supply_below = 1'b1;
    cyc(3);
    chk_bit(detector_irq_flag, 1'b0, "supply ignored");
    pin_below = 1'b1;
    cyc(3);
    chk_bit(detector_irq_flag, 1'b1, "pin low");
    {pin_below, supply_below} = 2'b00;
    clr();
    detector_irq_mask = 1'b1;
    wctrl(1'b1, lvdc_pkg::LVDC_ACT_RESET, lvdc_pkg::LVDC_SRC_SUPPLY);
    chk_bit(detect_action_mode, 1'b1, "reset mode");
    cyc(3);
    chk_bit(internal_reset_req, 1'b0, "no reset when fine");
    supply_below = 1'b1;
    cyc(3);
    chk_bit(internal_reset_req, 1'b1, "reset on low");
    supply_below = 1'b0;
    cyc(3);
    chk_bit(internal_reset_req, 1'b0, "reset ends");
    // default start: warm reset skips settling, cold one waits
    do_rst(1'b0, 1'b1, 2);
    chk_bit(detector_enable, 1'b1, "default start");
    chk_bit(detect_valid, 1'b1, "warm valid");
    do_rst(1'b0, 1'b0, 2);
    chk_bit(detector_enable, 1'b1, "cold start");
    chk_bit(detect_valid, 1'b0, "cold unsettled");
    end_sim();
  end
endmodule
`default_nettype wire
